// file: rtl/nab_norm_adjust.v
// Behaviour
// R1: perceptual adjustment only for full band; else norms pass unchanged.
// R2: transient: spectral norm is mean of its aligned four; else copy.
// R3: auditory value = member sum / member count + tabulated offset.
// R4: auditory band count 17, 18 or 20 by bitrate.
// R5: forward smooth: max of value and previous updated value minus 4.
// R6: backward smooth from second-highest band: max with next minus 8.
// R7: threshold: offset minus max of value and hearing pseudo-threshold.
// R8: rescale linearly so frame minimum is 0 and maximum is 4.
// R9: each band takes the rescaled value of its auditory band.
// R10: transient: band adjustment replaced by mean of aligned four.
// R11: allocation norm = quantized norm plus adjustment.
// R12: group split only for wideband non-transient at 24.4 or 32 kb/s.
// R13: mean of norms 10..17 over 8 lifts low norms of bands 0..3.
// R14: one bit per sub-band; groups are 0-15, 16-23, 24-25.
// R15: factors start at 2 and 3; group means and their sum.
// R16: differences of group means 0-1 and 1-2.
// R17: steep: group 0 share, group 1 0.92 share, group 2 remainder.
// R18: else each group gets floor of budget times mean over sum.
// R19: loud top group: cap at 288, 256, 96, excess saved.
// R20: saved bits: half to group 0 or 1, then remainder fix-up.
// R21: after redistribution factors become 2 and 1.5.
// R22: top group under 3 bits: move them to group 1.
// R23: budget = frame bits minus signalling, envelope and noise bits.
// R24: proportional shares truncate; steps run once per frame in order.
// R25: equal max and min: all rescaled values are zero.
`include "nab_consts.vh"
module nab_norm_adjust (
   input wire ref_clk,
   input wire arst_n,
   input wire ld_valid,
   output wire ld_ready,
   input wire [5:0] ld_idx,
   input wire [5:0] ld_norm,
   input wire start,
   input wire [1:0] bw_sel,
   input wire [1:0] rate_sel,
   input wire transient_flag,
   input wire [12:0] frame_bits,
   input wire [12:0] sig_bits,
   input wire [12:0] env_bits,
   input wire [12:0] noise_bits,
   input wire noise_en,
   output wire busy,
   output wire out_valid,
   output wire [5:0] out_idx,
   output wire [10:0] out_alloc_norm,
   output wire grp_valid,
   output wire [12:0] grp_budget0,
   output wire [12:0] grp_budget1,
   output wire [12:0] grp_budget2,
   output wire [3:0] norm_modi0,
   output wire [3:0] norm_modi1,
   output wire done
);
   localparam S_IDLE = 5'd0, S_MAPB = 5'd1, S_AUDS = 5'd2, S_AUDD = 5'd3;
   localparam S_FWD = 5'd4, S_BWD = 5'd5, S_THR = 5'd6, S_RESC = 5'd7;
   localparam S_RESW = 5'd8, S_ADJ = 5'd9, S_ADJT = 5'd10, S_OUT = 5'd11;
   localparam S_GSUM = 5'd12, S_GDIV = 5'd13, S_GWAIT = 5'd14;
   localparam S_GCAP = 5'd15, S_FIN = 5'd16;

   function [5:0] pstart(input [4:0] p);
      case (p)
         5'd10: pstart = 6'd10;
         5'd11: pstart = 6'd12;
         5'd12: pstart = 6'd14;
         5'd13: pstart = 6'd16;
         5'd14: pstart = 6'd18;
         5'd15: pstart = 6'd20;
         5'd16: pstart = 6'd24;
         5'd17: pstart = 6'd27;
         5'd18: pstart = 6'd30;
         5'd19: pstart = 6'd35;
         default: pstart = {1'b0, p};
      endcase
   endfunction

   function [3:0] hcnt(input [4:0] p);
      if (p < 5'd10) hcnt = 4'h1;
      else if (p < 5'd15) hcnt = 4'h2;
      else if (p == 5'd15) hcnt = 4'h4;
      else if (p < 5'd18) hcnt = 4'h3;
      else if (p == 5'd18) hcnt = 4'h5;
      else hcnt = 4'h9;
   endfunction

   function [11:0] toffq(input [4:0] p);
      reg [3:0] t;
      begin
         if (p < 5'd10) t = 4'h3;
         else if (p < 5'd13) t = 4'h4;
         else if (p < 5'd15) t = 4'h5;
         else if (p < 5'd18) t = 4'h6;
         else if (p == 5'd18) t = 4'h7;
         else t = 4'h8;
         toffq = {4'h0, t, 4'h0};
      end
   endfunction

   function [11:0] athrq(input [4:0] p);
      reg [3:0] a;
      begin
         case (p)
            5'd0: a = 4'h8;
            5'd1: a = 4'h6;
            5'd16: a = 4'h4;
            5'd17: a = 4'h5;
            5'd18: a = 4'h7;
            5'd19: a = 4'hB;
            default: a = 4'h3;
         endcase
         athrq = {4'h0, a, 4'h0};
      end
   endfunction

   function [4:0] band2p(input [5:0] b);
      integer k;
      begin
         band2p = 5'd0;
         for (k = 0; k < 20; k = k + 1) begin
            if (pstart(k[4:0]) <= b) band2p = k[4:0];
         end
      end
   endfunction

   function signed [11:0] smax(input signed [11:0] a, input signed [11:0] b);
      smax = (a > b) ? a : b;
   endfunction

   reg [4:0] st_r;
   reg [5:0] nrm_r [0:43];
   reg signed [11:0] bq_r [0:43];
   reg signed [11:0] mp_r [0:19];
   reg [11:0] adj_r [0:43];
   reg [5:0] bi_r;
   reg [4:0] pi_r;
   reg [4:0] nmap_r;
   reg [5:0] nb_r;
   reg [15:0] acc_r;
   reg signed [11:0] mn_r, mx_r;
   reg fb_r, tr_r, wbg_r;
   reg [12:0] tot_r;
   reg [15:0] s0_r, s1_r, s2_r;
   reg [1:0] gs_r;
   reg [12:0] r0_r, r1_r, r2_r;
   reg [3:0] modi0_r, modi1_r;
   reg div_start_r;
   reg [31:0] div_num_r, div_den_r;
   reg out_valid_r, grp_valid_r, done_r;
   reg [5:0] out_idx_r;
   reg [10:0] out_norm_r;
   wire [31:0] div_q;
   wire div_done;

   nab_divider nab_divider_inst (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .start(div_start_r),
      .num(div_num_r),
      .den(div_den_r),
      .quot(div_q),
      .done(div_done)
   );

   wire [13:0] noise_use = noise_en ? {1'b0, noise_bits} : 14'h0;
   wire [13:0] spend = {1'b0, sig_bits} + {1'b0, env_bits} + noise_use;
   wire [12:0] tot_nxt = ({1'b0, frame_bits} > spend) ?
      frame_bits - spend[12:0] : 13'h0; // R23
   wire [5:0] g4 = {bi_r[5:2], 2'b00};
   wire [7:0] sum4 = {2'h0, nrm_r[g4]} + {2'h0, nrm_r[g4 + 6'd1]} +
      {2'h0, nrm_r[g4 + 6'd2]} + {2'h0, nrm_r[g4 + 6'd3]};
   wire [13:0] adj4 = {2'h0, adj_r[bi_r]} + {2'h0, adj_r[bi_r + 6'd1]} +
      {2'h0, adj_r[bi_r + 6'd2]} + {2'h0, adj_r[bi_r + 6'd3]};
   wire [5:0] pend = pstart(pi_r) + {2'h0, hcnt(pi_r)} - 6'd1;
   wire signed [11:0] thr_v = $signed(toffq(pi_r)) -
      smax(mp_r[pi_r], $signed(athrq(pi_r))); // R7
   wire [11:0] span = mx_r - mn_r;
   wire [11:0] rel = mp_r[pi_r] - mn_r;
   wire [4:0] pb = band2p(bi_r);
   // mid-band mean in 1/16 units: sum of eight norms over 8 times 16
   wire [8:0] mid_sum = {3'h0, nrm_r[10]} + {3'h0, nrm_r[11]} +
      {3'h0, nrm_r[12]} + {3'h0, nrm_r[13]} + {3'h0, nrm_r[14]} +
      {3'h0, nrm_r[15]} + {3'h0, nrm_r[16]} + {3'h0, nrm_r[17]};
   wire [11:0] mid_band_mean = {2'h0, mid_sum, 1'b0}; // R13
   wire [11:0] nq = {2'h0, nrm_r[bi_r], 4'h0};
   wire [11:0] gval = (bi_r < `NAB_RAISE_CNT && nq < mid_band_mean) ?
      mid_band_mean : nq; // R13
   wire [11:0] m0 = s0_r[15:4];
   wire [11:0] m1 = s1_r[14:3];
   wire [11:0] m2 = s2_r[12:1];
   wire [11:0] gsum = m0 + m1 + m2; // R15
   wire signed [12:0] d0 = {1'b0, m0} - {1'b0, m1}; // R16
   wire signed [12:0] d1 = {1'b0, m1} - {1'b0, m2}; // R16
   wire steep = d0 >= $signed({1'b0, `NAB_DIFF0_MIN}) ||
      d1 >= $signed({1'b0, `NAB_DIFF1_MIN}); // R17
   wire [11:0] gm = (gs_r == 2'd0) ? m0 : (gs_r == 2'd1) ? m1 : m2;
   wire [31:0] gprod = {19'h0, tot_r} * {20'h0, gm};
   wire share = (gs_r == 2'd1) && steep;

   // capping and saved-bit redistribution
   wire e0 = r0_r > `NAB_CAP0;
   wire e1 = r1_r > `NAB_CAP1;
   wire e2 = r2_r > `NAB_CAP2;
   wire [12:0] k0 = e0 ? `NAB_CAP0 : r0_r;
   wire [12:0] k1 = e1 ? `NAB_CAP1 : r1_r;
   wire [12:0] k2 = e2 ? `NAB_CAP2 : r2_r;
   wire [12:0] sav = (e0 ? r0_r - `NAB_CAP0 : 13'h0) +
      (e1 ? r1_r - `NAB_CAP1 : 13'h0) + (e2 ? r2_r - `NAB_CAP2 : 13'h0);
   wire hit0 = k0 == `NAB_CAP0;
   wire hit1 = k1 == `NAB_CAP1;
   wire [12:0] a0 = hit0 ? k0 : k0 + {1'b0, sav[12:1]}; // R20
   wire [12:0] a1 = hit0 ? k1 + {1'b0, sav[12:1]} : k1; // R20
   reg [12:0] c0, c1, c2;
   always @* begin
      c0 = k0;
      c1 = k1;
      c2 = k2;
      if (sav != 13'h0) begin
         c0 = a0;
         c1 = a1;
         if (!hit0 && !hit1) begin
            c1 = tot_r - a0 - k2; // R20
         end else begin
            c2 = tot_r - a0 - a1; // R20
         end
      end
   end

   // data arrays carry no reset; nrm_r is rewritten by each load, the others only in full-band frames
   always @(posedge ref_clk) begin
      if (st_r == S_IDLE && ld_valid && ld_idx < `NAB_NB_FB) begin
         nrm_r[ld_idx] <= ld_norm;
      end
      case (st_r)
         S_MAPB: bq_r[bi_r] <= tr_r ? $signed({2'h0, sum4, 2'h0}) :
            $signed({2'h0, nrm_r[bi_r], 4'h0}); // R2
         S_AUDD: if (div_done) begin
            mp_r[pi_r] <= div_q[11:0] + toffq(pi_r); // R3
         end
         S_FWD: mp_r[pi_r] <= smax(mp_r[pi_r],
            mp_r[pi_r - 5'd1] - $signed(`NAB_FWD_STEP)); // R5
         S_BWD: mp_r[pi_r] <= smax(mp_r[pi_r],
            mp_r[pi_r + 5'd1] - $signed(`NAB_BWD_STEP)); // R6
         S_THR: mp_r[pi_r] <= thr_v; // R7
         S_RESC: if (span == 12'h0) begin
            mp_r[pi_r] <= 12'sh0; // R25
         end
         S_RESW: if (div_done) begin
            mp_r[pi_r] <= div_q[11:0]; // R8
         end
         S_ADJ: adj_r[bi_r] <= (pb < nmap_r) ? mp_r[pb] : 12'h0; // R9
         S_ADJT: begin
            adj_r[bi_r] <= adj4[13:2]; // R10
            adj_r[bi_r + 6'd1] <= adj4[13:2];
            adj_r[bi_r + 6'd2] <= adj4[13:2];
            adj_r[bi_r + 6'd3] <= adj4[13:2];
         end
         default: ;
      endcase
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= S_IDLE;
         bi_r <= 6'h0;
         pi_r <= 5'h0;
         nmap_r <= 5'h0;
         nb_r <= 6'h0;
         acc_r <= 16'h0;
         mn_r <= 12'sh0;
         mx_r <= 12'sh0;
         fb_r <= 1'b0;
         tr_r <= 1'b0;
         wbg_r <= 1'b0;
         tot_r <= 13'h0;
         s0_r <= 16'h0;
         s1_r <= 16'h0;
         s2_r <= 16'h0;
         gs_r <= 2'h0;
         r0_r <= 13'h0;
         r1_r <= 13'h0;
         r2_r <= 13'h0;
         modi0_r <= `NAB_MODI0_INIT;
         modi1_r <= `NAB_MODI1_INIT;
         div_start_r <= 1'b0;
         div_num_r <= 32'h0;
         div_den_r <= 32'h0;
         out_valid_r <= 1'b0;
         out_idx_r <= 6'h0;
         out_norm_r <= 11'h0;
         grp_valid_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         out_valid_r <= 1'b0;
         done_r <= 1'b0;
         div_start_r <= 1'b0;
         case (st_r)
            S_IDLE: if (start) begin
               fb_r <= bw_sel == `NAB_BW_FB; // R1
               tr_r <= transient_flag;
               wbg_r <= bw_sel == `NAB_BW_WB && !transient_flag &&
                  (rate_sel == `NAB_RATE_24K4 ||
                  rate_sel == `NAB_RATE_32K); // R12
               nmap_r <= (rate_sel == `NAB_RATE_24K4) ? `NAB_NMAP_24K4 :
                  (rate_sel == `NAB_RATE_32K) ? `NAB_NMAP_32K :
                  `NAB_NMAP_64K; // R4
               nb_r <= (bw_sel == `NAB_BW_FB) ? `NAB_NB_FB :
                  (bw_sel == `NAB_BW_SWB) ? `NAB_NB_SWB : `NAB_NB_WB;
               tot_r <= tot_nxt;
               modi0_r <= `NAB_MODI0_INIT; // R15
               modi1_r <= `NAB_MODI1_INIT; // R15
               grp_valid_r <= 1'b0;
               r0_r <= 13'h0;
               r1_r <= 13'h0;
               r2_r <= 13'h0;
               s0_r <= 16'h0;
               s1_r <= 16'h0;
               s2_r <= 16'h0;
               gs_r <= 2'h0;
               bi_r <= 6'h0;
               st_r <= (bw_sel == `NAB_BW_FB) ? S_MAPB : S_OUT; // R1
            end
            S_MAPB: begin
               bi_r <= bi_r + 6'd1;
               if (bi_r == nb_r - 6'd1) begin
                  pi_r <= 5'h0;
                  bi_r <= 6'h0;
                  acc_r <= 16'h0;
                  st_r <= S_AUDS;
               end
            end
            S_AUDS: begin
               acc_r <= acc_r + {{4{bq_r[bi_r][11]}}, bq_r[bi_r]};
               bi_r <= bi_r + 6'd1;
               if (bi_r == pend) begin
                  div_num_r <= {16'h0, acc_r + {4'h0, bq_r[bi_r]}}; // R3
                  div_den_r <= {28'h0, hcnt(pi_r)};
                  div_start_r <= 1'b1;
                  st_r <= S_AUDD;
               end
            end
            S_AUDD: if (div_done) begin
               acc_r <= 16'h0;
               pi_r <= pi_r + 5'd1;
               st_r <= S_AUDS;
               if (pi_r == nmap_r - 5'd1) begin
                  pi_r <= 5'd1;
                  st_r <= S_FWD;
               end
            end
            S_FWD: begin
               pi_r <= pi_r + 5'd1; // R5
               if (pi_r == nmap_r - 5'd1) begin
                  pi_r <= nmap_r - 5'd2;
                  st_r <= S_BWD;
               end
            end
            S_BWD: begin
               pi_r <= (pi_r == 5'd0) ? 5'd0 : pi_r - 5'd1; // R6
               if (pi_r == 5'd0) st_r <= S_THR;
            end
            S_THR: begin
               mn_r <= (pi_r == 5'd0 || thr_v < mn_r) ? thr_v : mn_r;
               mx_r <= (pi_r == 5'd0 || thr_v > mx_r) ? thr_v : mx_r;
               pi_r <= pi_r + 5'd1;
               if (pi_r == nmap_r - 5'd1) begin
                  pi_r <= 5'd0;
                  bi_r <= 6'h0;
                  st_r <= S_RESC;
               end
            end
            S_RESC: if (span == 12'h0) begin
               pi_r <= pi_r + 5'd1; // R25
               if (pi_r == nmap_r - 5'd1) st_r <= S_ADJ;
            end else begin
               div_num_r <= {14'h0, rel, 6'h0}; // R8
               div_den_r <= {20'h0, span};
               div_start_r <= 1'b1;
               st_r <= S_RESW;
            end
            S_RESW: if (div_done) begin
               pi_r <= pi_r + 5'd1;
               st_r <= (pi_r == nmap_r - 5'd1) ? S_ADJ : S_RESC;
            end
            S_ADJ: begin
               bi_r <= bi_r + 6'd1;
               if (bi_r == nb_r - 6'd1) begin
                  bi_r <= 6'h0;
                  st_r <= tr_r ? S_ADJT : S_OUT; // R10
               end
            end
            S_ADJT: begin
               bi_r <= bi_r + 6'd4;
               if (bi_r == nb_r - 6'd4) begin
                  bi_r <= 6'h0;
                  st_r <= S_OUT;
               end
            end
            S_OUT: begin
               out_valid_r <= 1'b1;
               out_idx_r <= bi_r;
               out_norm_r <= {1'b0, nrm_r[bi_r], 4'h0} +
                  (fb_r ? adj_r[bi_r][10:0] : 11'h0); // R11
               bi_r <= bi_r + 6'd1;
               if (bi_r == nb_r - 6'd1) begin
                  bi_r <= 6'h0;
                  st_r <= wbg_r ? S_GSUM : S_FIN; // R12
               end
            end
            S_GSUM: begin
               if (bi_r < `NAB_G1_START) s0_r <= s0_r + {4'h0, gval}; // R14
               else if (bi_r < `NAB_G2_START) s1_r <= s1_r + {4'h0, gval};
               else s2_r <= s2_r + {4'h0, gval};
               bi_r <= bi_r + 6'd1;
               if (bi_r == nb_r - 6'd1) st_r <= S_GDIV;
            end
            S_GDIV: if (gsum == 12'h0) begin
               st_r <= S_FIN;
            end else begin
               div_num_r <= share ? gprod * `NAB_SHARE_NUM : gprod; // R17
               div_den_r <= share ? {20'h0, gsum} * `NAB_SHARE_DEN :
                  {20'h0, gsum}; // R18
               div_start_r <= 1'b1;
               st_r <= S_GWAIT;
            end
            S_GWAIT: if (div_done) begin
               gs_r <= gs_r + 2'd1;
               st_r <= S_GDIV;
               case (gs_r)
                  2'd0: r0_r <= div_q[12:0]; // R24
                  2'd1: begin
                     r1_r <= div_q[12:0];
                     if (steep) begin
                        r2_r <= tot_r - r0_r - div_q[12:0]; // R17
                        st_r <= S_FIN;
                     end
                  end
                  default: begin
                     r2_r <= div_q[12:0]; // R18
                     st_r <= S_GCAP;
                  end
               endcase
            end
            S_GCAP: begin
               if (m2 > `NAB_G2_LOUD) begin
                  r0_r <= c0; // R19
                  r1_r <= c1;
                  r2_r <= c2;
                  modi1_r <= `NAB_MODI1_RESET; // R21
               end
               st_r <= S_FIN;
            end
            S_FIN: begin
               if (wbg_r && r2_r < `NAB_G2_MIN) begin
                  r1_r <= r1_r + r2_r; // R22
                  r2_r <= 13'h0;
               end
               grp_valid_r <= wbg_r;
               done_r <= 1'b1;
               st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   assign ld_ready = st_r == S_IDLE;
   assign busy = st_r != S_IDLE;
   assign out_valid = out_valid_r;
   assign out_idx = out_idx_r;
   assign out_alloc_norm = out_norm_r;
   assign grp_valid = grp_valid_r;
   assign grp_budget0 = r0_r;
   assign grp_budget1 = r1_r;
   assign grp_budget2 = r2_r;
   assign norm_modi0 = modi0_r;
   assign norm_modi1 = modi1_r;
   assign done = done_r;
endmodule // nab_norm_adjust

// file: common/nab_consts.vh
`ifndef NAB_CONSTS_VH
`define NAB_CONSTS_VH

// fixed point: norms and adjustments carry 4 fraction bits
`define NAB_FRAC 4
`define NAB_BW_WB 2'h1
`define NAB_BW_SWB 2'h2
`define NAB_BW_FB 2'h3
`define NAB_RATE_24K4 2'h0
`define NAB_RATE_32K 2'h1
`define NAB_RATE_64K 2'h2
`define NAB_NMAP_24K4 5'h11
`define NAB_NMAP_32K 5'h12
`define NAB_NMAP_64K 5'h14
`define NAB_NB_WB 6'h1A
`define NAB_NB_SWB 6'h27
`define NAB_NB_FB 6'h2C
`define NAB_FWD_STEP 12'h040
`define NAB_BWD_STEP 12'h080
`define NAB_RESC_SHIFT 6
`define NAB_MID_LO 6'h0A
`define NAB_MID_HI 6'h11
`define NAB_RAISE_CNT 6'h04
`define NAB_G1_START 6'h10
`define NAB_G2_START 6'h18
`define NAB_DIFF0_MIN 12'h060
`define NAB_DIFF1_MIN 12'h03C
`define NAB_SHARE_NUM 32'h0000005C
`define NAB_SHARE_DEN 32'h00000064
`define NAB_CAP0 13'h0120
`define NAB_CAP1 13'h0100
`define NAB_CAP2 13'h0060
`define NAB_G2_LOUD 12'h0C0
`define NAB_G2_MIN 13'h0003
`define NAB_MODI0_INIT 4'h4
`define NAB_MODI1_INIT 4'h6
`define NAB_MODI1_RESET 4'h3

`endif

// file: rtl/nab_divider.v
// unsigned restoring divider, one quotient bit per clock
module nab_divider (
   input wire ref_clk,
   input wire arst_n,
   input wire start,
   input wire [31:0] num,
   input wire [31:0] den,
   output wire [31:0] quot,
   output wire done
);
   reg [31:0] q_r;
   reg [32:0] rem_r;
   reg [31:0] d_r;
   reg [5:0] cnt_r;
   reg busy_r;
   reg done_r;
   wire [32:0] shifted = {rem_r[31:0], q_r[31]};
   wire fits = shifted >= {1'b0, d_r};

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         q_r <= 32'h0;
         rem_r <= 33'h0;
         d_r <= 32'h0;
         cnt_r <= 6'h0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            q_r <= num;
            rem_r <= 33'h0;
            d_r <= den;
            cnt_r <= 6'h20;
            busy_r <= 1'b1;
         end else if (busy_r) begin
            rem_r <= fits ? shifted - {1'b0, d_r} : shifted;
            q_r <= {q_r[30:0], fits};
            cnt_r <= cnt_r - 6'h01;
            if (cnt_r == 6'h01) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

   assign quot = q_r;
   assign done = done_r;
endmodule // nab_divider

// file: verif/nab_norm_adjust_properties.sv
module nab_norm_adjust_props (
   input wire ref_clk,
   input wire arst_n,
   input wire start,
   input wire [1:0] bw_sel,
   input wire ld_ready,
   input wire busy,
   input wire out_valid,
   input wire [5:0] out_idx,
   input wire [10:0] out_alloc_norm,
   input wire grp_valid,
   input wire [12:0] grp_budget2,
   input wire [3:0] norm_modi0,
   input wire [3:0] norm_modi1,
   input wire done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   a_ready_drop: assert property ($fell(ld_ready) |-> $past(start))
      else $error("load ready fell without start");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_done_idle: assert property (done |-> !busy)
      else $error("busy while done");
   a_frame_go: assert property (start && !busy |=> busy && !grp_valid)
      else $error("start not taken");
   a_burst_begin: assert property (start && !busy && bw_sel != 2'h3
      |-> ##2 out_valid && out_idx == 6'h00)
      else $error("pass-through burst late");
   a_idx_ascend: assert property (out_valid && $past(out_valid)
      |-> out_idx == $past(out_idx) + 6'h01)
      else $error("band order broken");
   a_modi_first: assert property (norm_modi0 == 4'h4)
      else $error("first factor wrong");
   a_modi_second: assert property (norm_modi1 inside {4'h3, 4'h6})
      else $error("second factor wrong");
   a_top_floor: assert property (grp_valid |-> grp_budget2 == 13'h0000
      || grp_budget2 >= 13'h0003)
      else $error("top group under minimum");
   a_norm_max: assert property (out_valid |-> out_alloc_norm <= 11'h2B0)
      else $error("allocation norm too large");
endmodule // nab_norm_adjust_props

bind nab_norm_adjust nab_norm_adjust_props nab_norm_adjust_props_inst (
   .ref_clk(ref_clk), .arst_n(arst_n), .start(start), .bw_sel(bw_sel),
   .ld_ready(ld_ready), .busy(busy), .out_valid(out_valid),
   .out_idx(out_idx), .out_alloc_norm(out_alloc_norm),
   .grp_valid(grp_valid), .grp_budget2(grp_budget2),
   .norm_modi0(norm_modi0), .norm_modi1(norm_modi1), .done(done));

// file: verif/nab_norm_source.sv
module nab_norm_source (
   input wire ref_clk,
   input wire go,
   input wire [5:0] norms [44],
   input wire ld_ready,
   output logic ld_valid,
   output logic [5:0] ld_idx,
   output logic [5:0] ld_norm,
   output logic loaded
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ld_valid = 1'b0;
      ld_idx = 6'h3F;
      ld_norm = 6'h00;
      loaded = 1'b0;
   end
   // one norm per beat, held until an edge that sees ready high
   always @(posedge go) begin
      loaded = 1'b0;
      for (int i = 0; i < 44; i++) begin
         @(posedge ref_clk);
         #1;
         ld_valid = 1'b1;
         ld_idx = i[5:0];
         ld_norm = norms[i];
         while (ld_ready !== 1'b1) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      #1;
      // released lines flip so a stale value is never mistaken for data
      ld_valid = 1'b0;
      ld_idx = ~ld_idx;
      ld_norm = ~ld_norm;
      loaded = 1'b1;
   end
endmodule // nab_norm_source

// file: verif/tb_norm_adjust_group_bit_allocator.sv
module tb_norm_adjust_group_bit_allocator;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic start = 1'b0;
   logic go = 1'b0;
   logic noise_en = 1'b0;
   logic transient_flag = 1'b0;
   logic [1:0] bw_sel = 2'h1;
   logic [1:0] rate_sel = 2'h0;
   logic [12:0] frame_bits = 13'h0000, noise_bits = 13'h0000;
   logic [12:0] sig_bits = 13'h0000, env_bits = 13'h0000;
   logic [5:0] norms [44];
   logic [10:0] seen [44];
   wire ld_valid, ld_ready, busy, out_valid, grp_valid, done, loaded;
   wire [5:0] ld_idx, ld_norm, out_idx;
   wire [10:0] out_alloc_norm;
   wire [12:0] grp_budget0, grp_budget1, grp_budget2;
   wire [3:0] norm_modi0, norm_modi1;
   int n_out = 0;
   int n_errors = 0;
   int n_checks = 0;

   always #2.5 ref_clk = ~ref_clk;
   nab_norm_source nab_norm_source_inst (.ref_clk(ref_clk), .go(go),
      .norms(norms), .ld_ready(ld_ready), .ld_valid(ld_valid),
      .ld_idx(ld_idx), .ld_norm(ld_norm), .loaded(loaded));

   nab_norm_adjust nab_norm_adjust_inst (.ref_clk(ref_clk),
      .arst_n(arst_n), .ld_valid(ld_valid), .ld_ready(ld_ready),
      .ld_idx(ld_idx), .ld_norm(ld_norm), .start(start), .bw_sel(bw_sel),
      .rate_sel(rate_sel), .transient_flag(transient_flag),
      .frame_bits(frame_bits), .sig_bits(sig_bits), .env_bits(env_bits),
      .noise_bits(noise_bits), .noise_en(noise_en), .busy(busy),
      .out_valid(out_valid), .out_idx(out_idx),
      .out_alloc_norm(out_alloc_norm), .grp_valid(grp_valid),
      .grp_budget0(grp_budget0), .grp_budget1(grp_budget1),
      .grp_budget2(grp_budget2), .norm_modi0(norm_modi0),
      .norm_modi1(norm_modi1), .done(done));

   always @(posedge ref_clk) begin
      if (start === 1'b1) n_out <= 0;
      if (out_valid === 1'b1) begin
         seen[out_idx] <= out_alloc_norm;
         n_out <= n_out + 1;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   // rescale divides in fixed point, so a few Q4 steps of slack
   task automatic near(input int b, input int exp);
      check({31'h0, seen[b] + 12'h004 >= exp && seen[b] <= exp + 4},
         32'h1, "adjust");
   endtask

   task automatic run_frame(input logic [1:0] bw, rate, input logic tr,
      input logic [12:0] fb, input logic [12:0] nz, input logic ne);
      @(posedge ref_clk);
      #1;
      bw_sel = bw;
      rate_sel = rate;
      transient_flag = tr;
      frame_bits = fb;
      sig_bits = 13'h0014;
      env_bits = 13'h003C;
      noise_bits = nz;
      noise_en = ne;
      go = 1'b1;
      @(posedge ref_clk);
      #1;
      go = 1'b0;
      for (int k = 0; k < 200 && loaded !== 1'b1; k++) @(posedge ref_clk);
      #1;
      start = 1'b1;
      @(posedge ref_clk);
      #1;
      start = 1'b0;
      for (int k = 0; k < 20000 && done !== 1'b1; k++) begin
         @(posedge ref_clk);
         #1;
      end
      check(done, 32'h1, "done");
   endtask

   task automatic t_pass;
      logic [1:0] bw [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
      logic [1:0] rt [4] = '{2'h0, 2'h2, 2'h0, 2'h0};
      int nb [4] = '{26, 26, 26, 39};
      for (int i = 0; i < 44; i++) norms[i] = 6'(i % 40);
      for (int j = 0; j < 4; j++) begin
         run_frame(bw[j], rt[j], j != 1, 13'h0100, 13'h0010, 1'b1);
         check(n_out, nb[j], "count");
         check(grp_valid, 32'h0, "group flag");
         for (int i = 0; i < nb[j]; i++)
            check(seen[i], {norms[i], 4'h0}, "norm");
      end
      $display("t_pass done");
   endtask

   task automatic t_group_steep;
      for (int i = 0; i < 44; i++)
         norms[i] = i < 4 ? 6'h0A : i < 16 ? 6'h1E : i < 24 ? 6'h14 : 6'h00;
      run_frame(2'h1, 2'h0, 1'b0, 13'h0078, 13'h000A, 1'b1);
      check(grp_valid, 32'h1, "group flag");
      check(grp_budget0, 32'h11, "group 0");
      check(grp_budget1, 32'h0D, "group 1");
      check(grp_budget2, 32'h0, "group 2");
      check(norm_modi1, 32'h6, "factor");
      $display("t_group_steep done");
   endtask

   task automatic t_group_even;
      logic [5:0] v [2] = '{6'h0E, 6'h0A};
      logic [12:0] fb [2] = '{13'h0398, 13'h01A4};
      logic [12:0] g0 [2] = '{13'h0180, 13'h0064};
      logic [12:0] g2 [2] = '{13'h00C8, 13'h0064};
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 44; i++) norms[i] = v[j];
         run_frame(2'h1, j == 0, 1'b0, fb[j], 13'h0028, j[0]);
         check(grp_budget0, g0[j], "group 0");
         check(grp_budget1, j ? 32'h64 : 32'h100, "group 1");
         check(grp_budget2, g2[j], "group 2");
         check(norm_modi1, j ? 32'h6 : 32'h3, "factor");
         check(norm_modi0, 32'h4, "factor");
      end
      $display("t_group_even done");
   endtask

   task automatic t_full_band;
      for (int i = 0; i < 44; i++) norms[i] = 6'h14;
      run_frame(2'h3, 2'h2, 1'b0, 13'h0200, 13'h0000, 1'b0);
      check(n_out, 32'd44, "count");
      for (int i = 0; i < 44; i++) check(seen[i], 32'h140, "flat");
      for (int i = 0; i < 44; i++) norms[i] = 6'h00;
      for (int r = 0; r < 3; r++) begin
         run_frame(2'h3, r[1:0], 1'b0, 13'h0200, 13'h0000, 1'b0);
         check(seen[0], 32'h0, "band 0");
         near(5, 64);
         near(1, 26);
         near(28, r == 0 ? 0 : 64);
         near(40, r == 2 ? 26 : 0);
      end
      run_frame(2'h3, 2'h2, 1'b1, 13'h0200, 13'h0000, 1'b0);
      near(0, 38);
      near(3, 38);
      near(6, 64);
      $display("t_full_band done");
   endtask

   task complete_run;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // about five full-band frames of under two thousand cycles each, plus slack
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_errors++;
      $display("FAIL %0t watchdog expired", $time);
      complete_run;
   end

   initial begin
      for (int i = 0; i < 44; i++) norms[i] = 6'h00;
      repeat (2) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      t_pass;
      t_group_steep;
      t_group_even;
      t_full_band;
      complete_run;
   end
endmodule // tb_norm_adjust_group_bit_allocator
